// ===== pkg/ufc_pkg.sv
// Behaviour
// - Enhanced feature bit 6 enables automatic hold-off; the output starts low.
// - Hold-off goes high once receive count exceeds the upper threshold.
// - Raised hold-off returns low only when the count equals the lower threshold or bit 6 is cleared.
// - 64-byte mode upper threshold is 8, 16, 56 or 60 from control bits 7:6.
// - 64-byte mode lower threshold is 0, 8, 16 or 56 from control bits 5:4.
// - Flow status bit 5 shows hold-off output level while hold-off is enabled.
// - With enable bit 6, a hold-off rise raises an interrupt; modem state read clears.
// - Hold-off rises only after the first stop bit of the character is sampled.
// - Enhanced feature bit 7 enables transmitter gating by the permit input.
// - Permit high stops new characters; a character in progress always completes.
// - Flow status bit 1 shows sampled permit level while gating is enabled.
// - Enhanced feature bits 3:2 choose the transmitted pause/resume characters.
// - Enhanced feature bits 1:0 choose the compared pause/resume characters.
// - A received pause suspends transmission; a received resume restarts it.
// - Transmit flow state starts as resume and sends nothing at enable.
// - Pause character is sent at once when receive count exceeds upper threshold.
// - After a pause, resume is sent only when count equals the lower threshold.
// - Flow status bit 4 reads zero in resume state, one after pause sent.
// - Transmit flow state never raises an interrupt.
// - 256-byte mode needs FIFO enable bit 0 and extra feature bit 0 both set.
// - With enable bit 5, received pause interrupts; interrupt source read or resume clears.
// - A pause suspension lets the character being shifted out finish.
package ufc_pkg;
  localparam int CNT_W  = 9;
  localparam int THR_W  = 8;
  localparam int CHAR_W = 8;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_EFR  = 8'h00;
  localparam logic [7:0] OFF_FCR  = 8'h04;
  localparam logic [7:0] OFF_AFR  = 8'h08;
  localparam logic [7:0] OFF_IER  = 8'h0c;
  localparam logic [7:0] OFF_ISR  = 8'h10;
  localparam logic [7:0] OFF_MSR  = 8'h14;
  localparam logic [7:0] OFF_FSR  = 8'h18;
  localparam logic [7:0] OFF_FUR  = 8'h1c;
  localparam logic [7:0] OFF_FLR  = 8'h20;
  localparam logic [7:0] OFF_CHR  = 8'h24;
  // Field positions
  localparam int EFR_CTS   = 7;
  localparam int EFR_RTS   = 6;
  localparam int IER_CTS   = 7;
  localparam int IER_RTS   = 6;
  localparam int IER_PAUSE = 5;
  localparam int FCR_EN    = 0;
  localparam int AFR_BIG   = 0;
  // Interrupt source codes
  localparam logic [5:0] ISR_NONE  = 6'h01;
  localparam logic [5:0] ISR_PAUSE = 6'h10;
  localparam logic [5:0] ISR_MODEM = 6'h20;
  // Fixed 64-byte mode thresholds
  localparam logic [THR_W-1:0] UP_0 = 8'h08;
  localparam logic [THR_W-1:0] UP_1 = 8'h10;
  localparam logic [THR_W-1:0] UP_2 = 8'h38;
  localparam logic [THR_W-1:0] UP_3 = 8'h3c;
  localparam logic [THR_W-1:0] LO_0 = 8'h00;
  localparam logic [THR_W-1:0] LO_1 = 8'h08;
  localparam logic [THR_W-1:0] LO_2 = 8'h10;
  localparam logic [THR_W-1:0] LO_3 = 8'h38;
  // Reset values
  localparam logic [THR_W-1:0]  FUR_RST = 8'h3c;
  localparam logic [THR_W-1:0]  FLR_RST = 8'h00;
  localparam logic [31:0]       CHR_RST = 32'h13131111;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {SND_IDLE, SND_FIRST, SND_SECOND} ufc_send_t;
endpackage

// ===== rtl/ufc_flow_ctrl.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
module ufc_flow_ctrl (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ufc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ufc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [ufc_pkg::CNT_W-1:0]   rx_level_count,
  input  wire logic                        rx_stop_sampled,
  input  wire logic                        rx_char_valid,
  input  wire logic [ufc_pkg::CHAR_W-1:0]  rx_char,
  output logic                             rx_char_is_flow,
  input  wire logic                        tx_permit_pin,
  output logic                             rx_hold_off_pin,
  output logic                             tx_start_ok,
  output logic                             fc_send_req,
  output logic [ufc_pkg::CHAR_W-1:0]       fc_send_char,
  input  wire logic                        fc_send_ack,
  output logic                             flow_int_pending
);
  import ufc_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]       enhanced_features_reg;
  logic [7:0]       fifo_ctrl_reg;
  logic [7:0]       extra_feature_reg;
  logic [7:0]       int_enable_reg;
  logic [THR_W-1:0] fur_wr;
  logic [THR_W-1:0] flr_wr;
  logic [31:0]      char_reg;
  logic [7:0]       flow_state_reg;
  logic [7:0]       int_source_reg;
  logic [7:0]       modem_state_reg;

  logic [CHAR_W-1:0] resume_char_a;
  logic [CHAR_W-1:0] resume_char_b;
  logic [CHAR_W-1:0] pause_char_a;
  logic [CHAR_W-1:0] pause_char_b;
  assign resume_char_a = char_reg[7:0];
  assign resume_char_b = char_reg[15:8];
  assign pause_char_a  = char_reg[23:16];
  assign pause_char_b  = char_reg[31:24];

  function automatic logic [THR_W-1:0] up_table(input logic [1:0] sel);
    unique case (sel)
      2'b00: up_table = UP_0;
      2'b01: up_table = UP_1;
      2'b10: up_table = UP_2;
      2'b11: up_table = UP_3;
    endcase
  endfunction

  function automatic logic [THR_W-1:0] lo_table(input logic [1:0] sel);
    unique case (sel)
      2'b00: lo_table = LO_0;
      2'b01: lo_table = LO_1;
      2'b10: lo_table = LO_2;
      2'b11: lo_table = LO_3;
    endcase
  endfunction

  logic             mode_big;
  logic [THR_W-1:0] rx_high_threshold;
  logic [THR_W-1:0] rx_low_threshold;
  assign mode_big = fifo_ctrl_reg[FCR_EN] & extra_feature_reg[AFR_BIG];
  // Written values are trusted to keep upper above lower
  assign rx_high_threshold = mode_big ? fur_wr : up_table(fifo_ctrl_reg[7:6]);
  assign rx_low_threshold  = mode_big ? flr_wr : lo_table(fifo_ctrl_reg[5:4]);

  logic above_high;
  logic at_low;
  assign above_high = rx_level_count > {1'b0, rx_high_threshold};
  assign at_low     = rx_level_count == {1'b0, rx_low_threshold};

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_do;
  logic              rd_do;
  logic              wr_hit;
  logic              rd_isr;
  logic              rd_msr;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign rd_isr = rd_do && s_axi_araddr == OFF_ISR;
  assign rd_msr = rd_do && s_axi_araddr == OFF_MSR;

  always_comb begin
    unique case (aw_addr)
      OFF_EFR, OFF_FCR, OFF_AFR, OFF_IER, OFF_ISR, OFF_MSR, OFF_FSR, OFF_FUR, OFF_FLR,
      OFF_CHR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Registers reset with every flow function off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enhanced_features_reg <= 8'h00;
      fifo_ctrl_reg         <= 8'h00;
      extra_feature_reg     <= 8'h00;
      int_enable_reg        <= 8'h00;
      fur_wr                <= FUR_RST;
      flr_wr                <= FLR_RST;
      char_reg              <= CHR_RST;
    end else if (wr_do && w_strb[0]) begin
      unique case (aw_addr)
        OFF_EFR: enhanced_features_reg <= w_data[7:0];
        OFF_FCR: fifo_ctrl_reg         <= w_data[7:0];
        OFF_AFR: extra_feature_reg     <= w_data[7:0];
        OFF_IER: int_enable_reg        <= w_data[7:0];
        OFF_FUR: if (mode_big) fur_wr <= w_data[7:0];
        OFF_FLR: if (mode_big) flr_wr <= w_data[7:0];
        OFF_CHR: char_reg[7:0]         <= w_data[7:0];
        default: ;
      endcase
    end
    if (aresetn && wr_do && aw_addr == OFF_CHR) begin
      if (w_strb[1]) char_reg[15:8]  <= w_data[15:8];
      if (w_strb[2]) char_reg[23:16] <= w_data[23:16];
      if (w_strb[3]) char_reg[31:24] <= w_data[31:24];
    end
  end

  logic [31:0] next_rdata;
  logic        next_rerr;
  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    unique case (s_axi_araddr)
      OFF_EFR: next_rdata[7:0] = enhanced_features_reg;
      OFF_FCR: next_rdata[7:0] = fifo_ctrl_reg;
      OFF_AFR: next_rdata[7:0] = extra_feature_reg;
      OFF_IER: next_rdata[7:0] = int_enable_reg;
      OFF_ISR: next_rdata[7:0] = int_source_reg;
      OFF_MSR: next_rdata[7:0] = modem_state_reg;
      OFF_FSR: next_rdata[7:0] = flow_state_reg;
      OFF_FUR: next_rdata[7:0] = rx_high_threshold;
      OFF_FLR: next_rdata[7:0] = rx_low_threshold;
      OFF_CHR: next_rdata      = char_reg;
      default: next_rerr       = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Hardware flow control
  // ************************************************************
  logic permit_meta;
  logic permit_sync;
  logic permit_prev;
  logic next_hold;
  logic hold_rise;
  logic permit_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      permit_meta <= 1'b0;
      permit_sync <= 1'b0;
      permit_prev <= 1'b0;
    end else begin
      permit_meta <= tx_permit_pin;
      permit_sync <= permit_meta;
      permit_prev <= permit_sync;
    end
  end
  assign permit_rise = permit_sync && !permit_prev;

  always_comb begin
    next_hold = rx_hold_off_pin;
    if (!enhanced_features_reg[EFR_RTS]) begin
      next_hold = 1'b0;
    end else if (!rx_hold_off_pin) begin
      // Upper crossing only counts once the stop bit is in
      if (rx_stop_sampled && above_high) next_hold = 1'b1;
    end else if (at_low) begin
      next_hold = 1'b0;
    end
  end
  assign hold_rise = next_hold && !rx_hold_off_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) rx_hold_off_pin <= 1'b0;
    else rx_hold_off_pin <= next_hold;
  end

  a_hold_off_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !enhanced_features_reg[EFR_RTS] |=> !rx_hold_off_pin)
    else $error("hold-off high while disabled");
  a_hold_rise_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rx_hold_off_pin) |-> $past(rx_stop_sampled && above_high))
    else $error("hold-off rose without stop bit over threshold");
  a_hold_rise_need: assert property (@(posedge aclk) disable iff (!aresetn)
    enhanced_features_reg[EFR_RTS] && !rx_hold_off_pin && rx_stop_sampled && above_high
    |=> rx_hold_off_pin)
    else $error("hold-off missed upper crossing");
  a_hold_fall_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(rx_hold_off_pin) && enhanced_features_reg[EFR_RTS] |-> $past(at_low))
    else $error("hold-off fell away from lower threshold");
  a_table_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_big && fifo_ctrl_reg[7:6] == 2'b10 |-> rx_high_threshold == UP_2)
    else $error("upper threshold table wrong");
  a_table_lower: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_big && fifo_ctrl_reg[5:4] == 2'b11 |-> rx_low_threshold == LO_3)
    else $error("lower threshold table wrong");

  // ************************************************************
  // Receive software flow control
  // ************************************************************
  logic              rx_sw_en;
  logic              rx_paused;
  logic              prev_res_a;
  logic              prev_pau_a;
  logic              got_resume;
  logic              got_pause;
  logic [CHAR_W-1:0] cmp_res;
  logic [CHAR_W-1:0] cmp_pau;
  logic              two_char;

  assign rx_sw_en = |enhanced_features_reg[1:0];
  assign two_char = &enhanced_features_reg[1:0];
  assign cmp_res  = enhanced_features_reg[1] ? resume_char_a : resume_char_b;
  assign cmp_pau  = enhanced_features_reg[1] ? pause_char_a : pause_char_b;

  // Equal resume and pause codes act as resume
  always_comb begin
    got_resume = 1'b0;
    got_pause  = 1'b0;
    if (rx_sw_en && rx_char_valid) begin
      if (two_char) begin
        got_resume = prev_res_a && rx_char == resume_char_b;
        got_pause  = !got_resume && prev_pau_a && rx_char == pause_char_b;
      end else begin
        got_resume = rx_char == cmp_res;
        got_pause  = !got_resume && rx_char == cmp_pau;
      end
    end
  end
  assign rx_char_is_flow = got_resume || got_pause;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_paused  <= 1'b0;
      prev_res_a <= 1'b0;
      prev_pau_a <= 1'b0;
    end else begin
      if (!rx_sw_en) rx_paused <= 1'b0;
      else if (got_pause) rx_paused <= 1'b1;
      else if (got_resume) rx_paused <= 1'b0;
      if (rx_char_valid) begin
        prev_res_a <= rx_char == resume_char_a;
        prev_pau_a <= rx_char == pause_char_a;
      end
    end
  end

  // Gating only blocks the next start, so a character in flight finishes
  assign tx_start_ok = !(enhanced_features_reg[EFR_CTS] && permit_sync)
                    && !(rx_sw_en && rx_paused);

  a_permit_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    enhanced_features_reg[EFR_CTS] && permit_sync |-> !tx_start_ok)
    else $error("start allowed while permit high");
  a_pause_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    got_pause && rx_sw_en ##1 rx_sw_en && !got_resume |-> !tx_start_ok)
    else $error("start allowed after pause received");

  // ************************************************************
  // Transmit software flow control
  // ************************************************************
  logic      tx_sw_en;
  logic      tx_paused;
  logic      snd_pause;
  ufc_send_t snd_state;

  assign tx_sw_en    = |enhanced_features_reg[3:2];
  assign fc_send_req = snd_state != SND_IDLE;

  // Enabling starts in resume state with nothing queued
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_sw_en) begin
      snd_state    <= SND_IDLE;
      snd_pause    <= 1'b0;
      tx_paused    <= 1'b0;
      fc_send_char <= 8'h00;
    end else begin
      unique case (snd_state)
        SND_IDLE: begin
          if (!tx_paused && above_high) begin
            snd_state    <= SND_FIRST;
            snd_pause    <= 1'b1;
            fc_send_char <= enhanced_features_reg[3] ? pause_char_a : pause_char_b;
          end else if (tx_paused && at_low) begin
            snd_state    <= SND_FIRST;
            snd_pause    <= 1'b0;
            fc_send_char <= enhanced_features_reg[3] ? resume_char_a : resume_char_b;
          end
        end
        SND_FIRST: begin
          if (fc_send_ack) begin
            if (&enhanced_features_reg[3:2]) begin
              snd_state    <= SND_SECOND;
              fc_send_char <= snd_pause ? pause_char_b : resume_char_b;
            end else begin
              snd_state <= SND_IDLE;
              tx_paused <= snd_pause;
            end
          end
        end
        SND_SECOND: begin
          if (fc_send_ack) begin
            snd_state <= SND_IDLE;
            tx_paused <= snd_pause;
          end
        end
      endcase
    end
  end

  a_resume_when_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fc_send_req) && !snd_pause |-> $past(at_low && tx_paused))
    else $error("resume sent away from lower threshold");
  a_pause_prompt: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_sw_en && snd_state == SND_IDLE && !tx_paused && above_high
    |=> fc_send_req && snd_pause)
    else $error("pause not sent at upper crossing");

  // ************************************************************
  // Status and interrupt sources
  // ************************************************************
  logic hold_flag;
  logic permit_flag;
  logic pause_flag;

  // A new event in the clearing read's cycle keeps its flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_flag   <= 1'b0;
      permit_flag <= 1'b0;
      pause_flag  <= 1'b0;
    end else begin
      if (int_enable_reg[IER_RTS] && hold_rise) hold_flag <= 1'b1;
      else if (rd_msr) hold_flag <= 1'b0;
      if (int_enable_reg[IER_CTS] && permit_rise) permit_flag <= 1'b1;
      else if (rd_msr) permit_flag <= 1'b0;
      if (int_enable_reg[IER_PAUSE] && got_pause) pause_flag <= 1'b1;
      else if (rd_isr || got_resume) pause_flag <= 1'b0;
    end
  end

  // Transmit flow state feeds no flag here
  assign flow_int_pending = hold_flag || permit_flag || pause_flag;

  always_comb begin
    int_source_reg = {2'b00, ISR_NONE};
    if (pause_flag) int_source_reg = {2'b00, ISR_PAUSE};
    else if (hold_flag || permit_flag) int_source_reg = {2'b00, ISR_MODEM};
  end

  assign modem_state_reg = {3'b000, permit_sync, 4'h0};
  assign flow_state_reg = {2'b00,
                           enhanced_features_reg[EFR_RTS] & rx_hold_off_pin,
                           tx_sw_en & tx_paused,
                           2'b00,
                           enhanced_features_reg[EFR_CTS] & permit_sync,
                           rx_sw_en & rx_paused};

  a_hold_int: assert property (@(posedge aclk) disable iff (!aresetn)
    int_enable_reg[IER_RTS] && hold_rise |=> flow_int_pending && int_source_reg != 8'h01)
    else $error("hold-off rise raised no interrupt");
  a_permit_int: assert property (@(posedge aclk) disable iff (!aresetn)
    int_enable_reg[IER_CTS] && permit_rise |=> permit_flag [*1] ##0 flow_int_pending)
    else $error("permit rise raised no interrupt");
  a_pause_int: assert property (@(posedge aclk) disable iff (!aresetn)
    int_enable_reg[IER_PAUSE] && got_pause |=> int_source_reg == {2'b00, ISR_PAUSE})
    else $error("pause raised no interrupt");
  a_tx_no_int: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_paused) && !$past(flow_int_pending) && $past(!(hold_rise || permit_rise
    || got_pause)) |-> !flow_int_pending)
    else $error("transmit flow state raised interrupt");
  a_status_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(rd_do && s_axi_araddr == OFF_FSR)
    |-> s_axi_rdata[5] == $past(enhanced_features_reg[EFR_RTS] & rx_hold_off_pin))
    else $error("status bit 5 does not follow hold-off");

endmodule // ufc_flow_ctrl

// ===== tb/ufc_tx_model.sv
module ufc_tx_model (
  input  wire logic aclk,
  input  wire logic req,
  output logic      ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] n = 2'd0;
  initial ack = 1'b0;
  // Takes a flow char only after a few cycles, as a busy shifter would
  always @(posedge aclk) begin
    ack <= req && !ack && n == 2'd3;
    n <= (req && !ack) ? n + 2'd1 : 2'd0;
  end
endmodule // ufc_tx_model

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ufc_pkg::*;
  logic        clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic        stop = 0, cv = 0, perm = 0, awr, wr_r, bv, arr, rv, isf, hold, sok, sreq, sack, ip;
  logic [7:0]  aw = 0, ar = 0, ch = 0, sc;
  logic [31:0] wd = 0, rdat, rdw, seed = 32'he622;
  logic [8:0]  cnt = 0;
  logic [1:0]  bresp, rresp, rrp;
  logic [7:0]  up [4] = '{UP_0, UP_1, UP_2, UP_3};
  logic [7:0]  lo [4] = '{LO_0, LO_1, LO_2, LO_3};
  int          err_total = 0, total_checks = 0;
  always #25 clk = ~clk;
  ufc_flow_ctrl uut (.aclk(clk), .aresetn(rstn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdw),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .rx_level_count(cnt),
    .rx_stop_sampled(stop), .rx_char_valid(cv), .rx_char(ch), .rx_char_is_flow(isf),
    .tx_permit_pin(perm), .rx_hold_off_pin(hold), .tx_start_ok(sok), .fc_send_req(sreq),
    .fc_send_char(sc), .fc_send_ack(sack), .flow_int_pending(ip));
  ufc_tx_model ptn (.aclk(clk), .req(sreq), .ack(sack));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Handshakes are sampled settled, 1 ns after an edge, and take effect at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic a_t, w_t, b_t;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    b_t = 1'b0;
    for (n = 0; n < 40 && !b_t; n++) begin
      #1;
      a_t = awv && awr === 1'b1;
      w_t = wv && wr_r === 1'b1;
      b_t = bv === 1'b1;
      @(posedge clk);
      if (a_t) awv <= 0;
      if (w_t) wv <= 0;
    end
    br <= 0;
    if (!b_t) chk("wr wait", 0, 1);
  endtask
  task automatic rd(input logic [7:0] a);
    int   n;
    logic a_t, r_t;
    @(posedge clk);
    ar <= a;
    arv <= 1;
    rr <= 1;
    r_t = 1'b0;
    for (n = 0; n < 40 && !r_t; n++) begin
      #1;
      a_t = arv && arr === 1'b1;
      r_t = rv === 1'b1;
      rdat = rdw;
      rrp = rresp;
      @(posedge clk);
      if (a_t) arv <= 0;
    end
    rr <= 0;
    if (!r_t) chk("rd wait", 0, 1);
  endtask
  task automatic stp(input logic [8:0] c);
    @(posedge clk) cnt <= c;
    @(posedge clk) stop <= 1;
    @(posedge clk) stop <= 0;
  endtask
  task automatic rxc(input logic [7:0] c);
    @(posedge clk) ch <= c;
    cv <= 1;
    #1 chk("flow char", 1, isf);
    @(posedge clk) cv <= 0;
  endtask
  task automatic wdrop;
    int n;
    for (n = 0; n < 40 && sreq === 1'b1; n++) @(posedge clk);
    if (n == 40) chk("ack wait", 0, 1);
  endtask
  initial begin
    #2000000;
    chk("timeout", 0, 1);
    end_sim;
  end
  initial begin
    tk(3);
    rstn <= 1;
    chk("hold", 0, hold);
    chk("start", 1, sok);
    chk("send", 0, sreq);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FCR, 32'({i[1:0], 2'(3 - i), 4'h1}));
      rd(OFF_FUR);
      chk("upper", 32'(up[i]), rdat);
      rd(OFF_FLR);
      chk("lower", 32'(lo[3 - i]), rdat);
    end
    rd(8'hfc);
    chk("resp", 32'(RESP_SLVERR), 32'(rrp));
    wr(OFF_FCR, 32'h01);
    wr(OFF_IER, 32'h40);
    wr(OFF_EFR, 32'h40);
    repeat (4) begin
      seed = xs(seed);
      stp(9'(seed[2:0]) + 9'd1);
      tk(1);
      chk("hold below", 0, hold);
    end
    @(posedge clk) cnt <= 9'd9;
    tk(3);
    chk("hold no stop", 0, hold);
    stp(9'd9);
    tk(1);
    chk("hold up", 1, hold);
    rd(OFF_FSR);
    chk("fsr5", 1, rdat[5]);
    rd(OFF_ISR);
    chk("isr", 32'(ISR_MODEM), 32'(rdat[5:0]));
    chk("int pend", 1, ip);
    rd(OFF_MSR);
    rd(OFF_ISR);
    chk("isr clr", 32'(ISR_NONE), 32'(rdat[5:0]));
    stp(9'd4);
    tk(2);
    chk("hold hyst", 1, hold);
    stp(9'd0);
    tk(2);
    chk("hold low", 0, hold);
    wr(OFF_EFR, 32'h08);
    tk(2);
    chk("no resume", 0, sreq);
    stp(9'd9);
    chk("pause req", 1, sreq);
    chk("pause char", 32'(CHR_RST[23:16]), 32'(sc));
    wdrop();
    rd(OFF_FSR);
    chk("fsr4", 1, rdat[4]);
    stp(9'd4);
    chk("no early resume", 0, sreq);
    stp(9'd0);
    chk("resume char", 32'(CHR_RST[7:0]), 32'(sc));
    wdrop();
    rd(OFF_FSR);
    chk("fsr4 clr", 0, rdat[4]);
    rd(OFF_ISR);
    chk("isr tx", 32'(ISR_NONE), 32'(rdat[5:0]));
    wr(OFF_EFR, 32'h82);
    @(posedge clk) perm <= 1;
    tk(4);
    chk("permit off", 0, sok);
    rd(OFF_FSR);
    chk("fsr1", 1, rdat[1]);
    @(posedge clk) perm <= 0;
    tk(4);
    rxc(CHR_RST[23:16]);
    tk(1);
    chk("rx pause", 0, sok);
    rxc(CHR_RST[7:0]);
    tk(1);
    chk("rx resume", 1, sok);
    end_sim;
  end
endmodule // testbench
